/* File: src/bch_config_header.sv */
`timescale 1ns/10ps
module bch_config_header
    import bch_pkg::*;
#(
    parameter logic [15:0] MAKER_ID = 16'h1AB0, // arbitrary value
    parameter logic [15:0] FUNC_ID = 16'h0C51, // arbitrary value
    parameter logic [7:0] REV_ID = 8'h01 // arbitrary value
) (
    input wire logic ref_clk_in, // 20 MHz clock
    input wire logic reset_n_in, // async reset, active low
    input wire logic cfg_req_in, // access request, one cycle
    input wire bch_req_t cfg_cmd_in, // access fields
    input wire logic sse_set_in, // primary system-error event
    input wire logic [15:0] dsts_set_in, // downstream status events
    output logic cfg_ack_out, // answer strobe
    output logic [31:0] cfg_rdata_out, // read data
    output bch_ctrl_t ctrl_out // live control values
);

    // merge the enabled byte of a write through a writable mask
    function automatic logic [7:0] wr8(input logic [7:0] old, input logic [7:0] d,
                                       input logic en, input logic [7:0] m);
        wr8 = en ? ((old & ~m) | (d & m)) : old;
    endfunction

    // 16-bit word split over two byte enables
    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [15:0] d,
                                         input logic [1:0] en, input logic [15:0] m);
        wr16 = {wr8(old[15:8], d[15:8], en[1], m[15:8]),
                wr8(old[7:0], d[7:0], en[0], m[7:0])};
    endfunction

    // write-one-to-clear, gated per byte lane
    function automatic logic [15:0] w1c16(input logic [15:0] d, input logic [1:0] en,
                                          input logic [15:0] m);
        w1c16 = d & {{8{en[1]}}, {8{en[0]}}} & m;
    endfunction

    // dword index and byte lane of a printed offset
    function automatic logic [5:0] dwi(input logic [7:0] off);
        dwi = off[7:2];
    endfunction

    function automatic int lane(input logic [7:0] off);
        lane = int'(off[1:0]);
    endfunction

    logic [15:0] cmd_q;
    logic [15:0] psts_q;
    logic [7:0] plt_q;
    logic [7:0] dbus_q;
    logic [7:0] hbus_q;
    logic [7:0] dlt_q;
    logic [7:0] iob_q;
    logic [7:0] iol_q;
    logic [15:0] dsts_q;
    logic [15:0] mb_q;
    logic [15:0] ml_q;
    logic [15:0] pb_q;
    logic [15:0] pl_q;
    logic [7:0] bctl_q;
    logic [7:0] err_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic ack_q;
    logic wr_en;
    logic [31:0] wd;
    logic [3:0] be;

    assign wr_en = cfg_req_in && cfg_cmd_in.wr;
    assign wd = cfg_cmd_in.wdata;
    assign be = cfg_cmd_in.be;

    // identity bytes have no storage, so writes cannot reach them
    // (see read mux)

    // command word and primary latency timer
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cmd_q <= BCH_RST_CMD;
            plt_q <= BCH_RST_ZERO8;
        end else if (wr_en) begin
            if (cfg_cmd_in.dw == dwi(BCH_OFF_CMD)) begin
                cmd_q <= wr16(cmd_q, wd[15:0], be[1:0], BCH_WM_CMD);
            end
            if (cfg_cmd_in.dw == dwi(BCH_OFF_PLT)) begin
                plt_q <= wr8(plt_q, wd[15:8], be[lane(BCH_OFF_PLT)], BCH_WM_LT);
            end
        end
    end

    // primary status: hardware set beats a same-cycle software clear
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            psts_q <= BCH_RST_PSTS;
        end else if (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_PSTS)) begin
            psts_q <= (psts_q & ~w1c16(wd[31:16], be[3:2], BCH_CM_PSTS))
                      | ({16{sse_set_in}} & BCH_CM_PSTS);
        end else begin
            psts_q <= psts_q | ({16{sse_set_in}} & BCH_CM_PSTS);
        end
    end

    // bus numbers and downstream latency timer
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dbus_q <= BCH_RST_ZERO8;
            hbus_q <= BCH_RST_ZERO8;
            dlt_q <= BCH_RST_ZERO8;
        end else if (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_UBUS)) begin
            dbus_q <= wr8(dbus_q, wd[15:8], be[lane(BCH_OFF_DBUS)], 8'hFF);
            hbus_q <= wr8(hbus_q, wd[23:16], be[lane(BCH_OFF_HBUS)], 8'hFF);
            dlt_q <= wr8(dlt_q, wd[31:24], be[lane(BCH_OFF_DLT)], BCH_WM_LT);
        end
    end

    // I/O window bytes
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            iob_q <= BCH_RST_IOB;
            iol_q <= BCH_RST_ZERO8;
        end else if (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_IOB)) begin
            iob_q <= wr8(iob_q, wd[7:0], be[lane(BCH_OFF_IOB)], BCH_WM_IO);
            iol_q <= wr8(iol_q, wd[15:8], be[lane(BCH_OFF_IOL)], BCH_WM_IO);
        end
    end

    // downstream status flags; a new event is never lost to a clear
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dsts_q <= BCH_RST_DSTS;
        end else if (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_DSTS)) begin
            dsts_q <= (dsts_q & ~w1c16(wd[31:16], be[3:2], BCH_CM_DSTS))
                      | (dsts_set_in & BCH_CM_DSTS);
        end else begin
            dsts_q <= dsts_q | (dsts_set_in & BCH_CM_DSTS);
        end
    end

    // memory and prefetchable windows; low nibble is fixed granularity
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mb_q <= BCH_RST_WBASE;
            ml_q <= BCH_RST_ZERO16;
            pb_q <= BCH_RST_WBASE;
            pl_q <= BCH_RST_ZERO16;
        end else if (wr_en) begin
            if (cfg_cmd_in.dw == dwi(BCH_OFF_MB)) begin
                mb_q <= wr16(mb_q, wd[15:0], be[1:0], BCH_WM_WIN);
                ml_q <= wr16(ml_q, wd[31:16], be[3:2], BCH_WM_WIN);
            end
            if (cfg_cmd_in.dw == dwi(BCH_OFF_PB)) begin
                pb_q <= wr16(pb_q, wd[15:0], be[1:0], BCH_WM_WIN);
                pl_q <= wr16(pl_q, wd[31:16], be[3:2], BCH_WM_WIN);
            end
        end
    end

    // bridge control and error command bytes
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bctl_q <= BCH_RST_ZERO8;
            err_q <= BCH_RST_ZERO8;
        end else if (wr_en) begin
            if (cfg_cmd_in.dw == dwi(BCH_OFF_BCTL)) begin
                bctl_q <= wr8(bctl_q, wd[23:16], be[lane(BCH_OFF_BCTL)], BCH_WM_BCTL);
            end
            if (cfg_cmd_in.dw == dwi(BCH_OFF_ERR)) begin
                err_q <= wr8(err_q, wd[7:0], be[lane(BCH_OFF_ERR)], BCH_WM_ERR);
            end
        end
    end

    // read mux; any dword not listed answers zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (cfg_cmd_in.dw)
            dwi(BCH_OFF_MAKER): rdata_d = {FUNC_ID, MAKER_ID};
            dwi(BCH_OFF_CMD): rdata_d = {psts_q, cmd_q};
            dwi(BCH_OFF_REV): rdata_d = {BCH_RST_BCC, BCH_RST_SUBC, 8'h00, REV_ID};
            dwi(BCH_OFF_PLT): rdata_d = {8'h00, BCH_RST_HDR, plt_q, 8'h00};
            dwi(BCH_OFF_UBUS): rdata_d = {dlt_q, hbus_q, dbus_q, BCH_RST_ZERO8};
            dwi(BCH_OFF_IOB): rdata_d = {dsts_q, iol_q, iob_q};
            dwi(BCH_OFF_MB): rdata_d = {ml_q, mb_q};
            dwi(BCH_OFF_PB): rdata_d = {pl_q, pb_q};
            dwi(BCH_OFF_BCTL): rdata_d = {8'h00, bctl_q, 16'h0000};
            dwi(BCH_OFF_ERR): rdata_d = {24'h000000, err_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // answer one cycle after each request; data held until next read
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= cfg_req_in;
            if (cfg_req_in && !cfg_cmd_in.wr) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign cfg_ack_out = ack_q;
    assign cfg_rdata_out = rdata_q;

    // control values feed the bridge's address decoders
    assign ctrl_out = '{cmd: cmd_q, dbus: dbus_q, hbus: hbus_q, io_base: iob_q,
                        io_limit: iol_q, mem_base: mb_q, mem_limit: ml_q, pf_base: pb_q,
                        pf_limit: pl_q, bctl: bctl_q, errcmd: err_q};

    // helper: is the request a read of a given dword
    function automatic logic rd_of(input logic req, input bch_req_t c, input logic [5:0] d);
        rd_of = req && !c.wr && c.dw == d;
    endfunction

    // an all-ones identity would read like an empty slot to enumeration software
    if (MAKER_ID == 16'hFFFF) begin : g_maker_check
        $error("maker id must not be all ones");
    end
    if (FUNC_ID == 16'hFFFF) begin : g_func_check
        $error("function id must not be all ones");
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_ack_follows: assert property (cfg_req_in |=> cfg_ack_out)
        else $error("no answer one cycle after request");
    a_ident_read: assert property (rd_of(cfg_req_in, cfg_cmd_in, dwi(BCH_OFF_MAKER))
        |=> cfg_rdata_out == {FUNC_ID, MAKER_ID})
        else $error("identity words wrong");
    a_rev_fixed: assert property (rd_of(cfg_req_in, cfg_cmd_in, dwi(BCH_OFF_REV))
        |=> cfg_rdata_out[7:0] == REV_ID)
        else $error("revision byte changed");
    a_cmd_mask: assert property ((cmd_q & ~BCH_WM_CMD) == 16'h0000)
        else $error("read-only command bit set");
    a_lat_mask: assert property ((plt_q & ~BCH_WM_LT) == 8'h00
        && (dlt_q & ~BCH_WM_LT) == 8'h00)
        else $error("latency timer read-only bit set");
    a_ubus_zero: assert property (rd_of(cfg_req_in, cfg_cmd_in, dwi(BCH_OFF_UBUS))
        |=> cfg_rdata_out[7:0] == 8'h00)
        else $error("upstream bus number not zero");
    a_hbus_write: assert property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_UBUS) && be[2]
        |=> hbus_q == $past(wd[23:16]))
        else $error("highest bus number not written");
    a_io_gran: assert property ((iob_q & ~BCH_WM_IO) == 8'h00
        && (iol_q & ~BCH_WM_IO) == 8'h00)
        else $error("io window low bits set");
    a_dsts_set_wins: assert property ((dsts_set_in & BCH_CM_DSTS) != 16'h0000
        |=> (dsts_q & $past(dsts_set_in & BCH_CM_DSTS)) == $past(dsts_set_in & BCH_CM_DSTS))
        else $error("status event lost");
    a_dsts_ro: assert property ((dsts_q & ~BCH_CM_DSTS) == (BCH_RST_DSTS & ~BCH_CM_DSTS))
        else $error("read-only status bits moved");
    a_win_gran: assert property ((mb_q[3:0] | ml_q[3:0] | pb_q[3:0] | pl_q[3:0]) == 4'h0)
        else $error("window low nibble set");
    a_bctl_mask: assert property ((bctl_q & ~BCH_WM_BCTL) == 8'h00)
        else $error("bridge control read-only bit set");
    a_rsvd_zero: assert property (rd_of(cfg_req_in, cfg_cmd_in, 6'h3F)
        |=> cfg_rdata_out == 32'h0000_0000)
        else $error("reserved dword not zero");

    // no request, no answer: a stuck strobe would fake completions
    a_ack_single: assert property (!cfg_req_in |=> !cfg_ack_out)
        else $error("answer without request");

    // read data only moves when a read is taken
    a_rdata_hold: assert property (!(cfg_req_in && !cfg_cmd_in.wr) |=> $stable(cfg_rdata_out))
        else $error("read data moved without read");

    // writable command bits of the low byte land, read-only ones there stay zero
    a_cmd_write: assert property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_CMD) && be[0]
        |=> cmd_q[7:0] == ($past(wd[7:0]) & BCH_WM_CMD[7:0]))
        else $error("command low byte not written");

    // primary latency timer keeps its low bits at zero
    a_plt_write: assert property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_PLT) && be[1]
        |=> plt_q == ($past(wd[15:8]) & BCH_WM_LT))
        else $error("primary latency timer not written");

    // header type is a constant of the read mux
    a_hdr_fixed: assert property (rd_of(cfg_req_in, cfg_cmd_in, dwi(BCH_OFF_PLT))
        |=> cfg_rdata_out[23:16] == BCH_RST_HDR)
        else $error("header type changed");

    // downstream bus number takes the whole byte
    a_dbus_write: assert property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_UBUS) && be[1]
        |=> dbus_q == $past(wd[15:8]))
        else $error("downstream bus number not written");

    // downstream latency timer, same mask as the primary one
    a_dlt_write: assert property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_UBUS) && be[3]
        |=> dlt_q == ($past(wd[31:24]) & BCH_WM_LT))
        else $error("downstream latency timer not written");

    // io window bytes keep their fixed low nibble
    a_io_write: assert property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_IOB) && be[0] && be[1]
        |=> iob_q == ($past(wd[7:0]) & BCH_WM_IO)
        && iol_q == ($past(wd[15:8]) & BCH_WM_IO))
        else $error("io window not written");

    // a one written to a flag clears it when no event arrives
    a_dsts_clear: assert property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_DSTS) && be[3]
        && wd[31] && !dsts_set_in[15] |=> !dsts_q[15])
        else $error("status flag not cleared");

    // memory window pair written through all four lanes
    a_mwin_write: assert property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_MB) && be == 4'hF
        |=> mb_q == ($past(wd[15:0]) & BCH_WM_WIN)
        && ml_q == ($past(wd[31:16]) & BCH_WM_WIN))
        else $error("memory window not written");

    // prefetchable window pair written through all four lanes
    a_pwin_write: assert property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_PB) && be == 4'hF
        |=> pb_q == ($past(wd[15:0]) & BCH_WM_WIN)
        && pl_q == ($past(wd[31:16]) & BCH_WM_WIN))
        else $error("prefetch window not written");

    // bridge control keeps unused bits at zero
    a_bctl_write: assert property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_BCTL) && be[2]
        |=> bctl_q == ($past(wd[23:16]) & BCH_WM_BCTL))
        else $error("bridge control not written");

    // error command byte takes its one writable bit
    a_err_write: assert property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_ERR) && be[0]
        |=> err_q == ($past(wd[7:0]) & BCH_WM_ERR))
        else $error("error command not written");

    // a write to a hole must not touch any live control value
    a_rsvd_nowrite: assert property (wr_en && cfg_cmd_in.dw == 6'h3F
        |=> ctrl_out == $past(ctrl_out))
        else $error("reserved write changed a register");

    // without a write every writable register holds
    a_idle_hold: assert property (!wr_en
        |=> $stable({cmd_q, plt_q, dbus_q, hbus_q, dlt_q, iob_q, iol_q,
                     mb_q, ml_q, pb_q, pl_q, bctl_q, err_q}))
        else $error("register moved without write");

    // only the system-error flag of primary status may move
    a_psts_ro: assert property ((psts_q & ~BCH_CM_PSTS) == (BCH_RST_PSTS & ~BCH_CM_PSTS))
        else $error("read-only primary status bits moved");

    // a system-error event always shows, even against a clear
    a_psts_set_wins: assert property (sse_set_in
        |=> (psts_q & BCH_CM_PSTS) == BCH_CM_PSTS)
        else $error("system error event lost");

    c_cmd_write: cover property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_CMD) ##1 cmd_q != 16'h0);
    c_status_clear: cover property (dsts_q[15] ##1 !dsts_q[15]);
    c_read_back: cover property (rd_of(cfg_req_in, cfg_cmd_in, dwi(BCH_OFF_MB)) ##1 cfg_ack_out);
    // event flag raised, and a bus number programmed
    c_psts_set: cover property (sse_set_in ##1 psts_q != BCH_RST_PSTS);
    c_bus_write: cover property (wr_en && cfg_cmd_in.dw == dwi(BCH_OFF_UBUS) ##1 dbus_q != 8'h00);

endmodule // bch_config_header

/* File: src/bch_pkg.sv */
package bch_pkg;
    // byte offsets of the bridge function's configuration space
    localparam logic [7:0] BCH_OFF_MAKER = 8'h00;
    localparam logic [7:0] BCH_OFF_FUNC = 8'h02;
    localparam logic [7:0] BCH_OFF_CMD = 8'h04;
    localparam logic [7:0] BCH_OFF_PSTS = 8'h06;
    localparam logic [7:0] BCH_OFF_REV = 8'h08;
    localparam logic [7:0] BCH_OFF_SUBC = 8'h0A;
    localparam logic [7:0] BCH_OFF_BCC = 8'h0B;
    localparam logic [7:0] BCH_OFF_PLT = 8'h0D;
    localparam logic [7:0] BCH_OFF_HDR = 8'h0E;
    localparam logic [7:0] BCH_OFF_UBUS = 8'h18;
    localparam logic [7:0] BCH_OFF_DBUS = 8'h19;
    localparam logic [7:0] BCH_OFF_HBUS = 8'h1A;
    localparam logic [7:0] BCH_OFF_DLT = 8'h1B;
    localparam logic [7:0] BCH_OFF_IOB = 8'h1C;
    localparam logic [7:0] BCH_OFF_IOL = 8'h1D;
    localparam logic [7:0] BCH_OFF_DSTS = 8'h1E;
    localparam logic [7:0] BCH_OFF_MB = 8'h20;
    localparam logic [7:0] BCH_OFF_ML = 8'h22;
    localparam logic [7:0] BCH_OFF_PB = 8'h24;
    localparam logic [7:0] BCH_OFF_PL = 8'h26;
    localparam logic [7:0] BCH_OFF_BCTL = 8'h3E;
    localparam logic [7:0] BCH_OFF_ERR = 8'h40;
    // reset values
    localparam logic [15:0] BCH_RST_CMD = 16'h0000;
    localparam logic [15:0] BCH_RST_PSTS = 16'h00A0;
    localparam logic [7:0] BCH_RST_SUBC = 8'h04;
    localparam logic [7:0] BCH_RST_BCC = 8'h06;
    localparam logic [7:0] BCH_RST_HDR = 8'h01;
    localparam logic [7:0] BCH_RST_ZERO8 = 8'h00;
    localparam logic [7:0] BCH_RST_IOB = 8'hF0;
    localparam logic [15:0] BCH_RST_DSTS = 16'h02A0;
    localparam logic [15:0] BCH_RST_WBASE = 16'hFFF0;
    localparam logic [15:0] BCH_RST_ZERO16 = 16'h0000;
    // writable and write-one-to-clear masks
    localparam logic [15:0] BCH_WM_CMD = 16'h0107;
    localparam logic [15:0] BCH_CM_PSTS = 16'h4000;
    localparam logic [7:0] BCH_WM_LT = 8'hF8;
    localparam logic [7:0] BCH_WM_IO = 8'hF0;
    localparam logic [15:0] BCH_CM_DSTS = 16'hF100;
    localparam logic [15:0] BCH_WM_WIN = 16'hFFF0;
    localparam logic [7:0] BCH_WM_BCTL = 8'h03;
    localparam logic [7:0] BCH_WM_ERR = 8'h01;

    // one configuration access
    typedef struct packed {
        logic wr;
        logic [5:0] dw;
        logic [3:0] be;
        logic [31:0] wdata;
    } bch_req_t;

    // values that steer the bridge's decode logic
    typedef struct packed {
        logic [15:0] cmd;
        logic [7:0] dbus;
        logic [7:0] hbus;
        logic [7:0] io_base;
        logic [7:0] io_limit;
        logic [15:0] mem_base;
        logic [15:0] mem_limit;
        logic [15:0] pf_base;
        logic [15:0] pf_limit;
        logic [7:0] bctl;
        logic [7:0] errcmd;
    } bch_ctrl_t;
endpackage

/* File: testbench/bch_config_header_tb_top.sv */
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value at %0t: got %h exp %h", $time, got, exp); end end
module bch_config_header_tb_top;
    import bch_pkg::*;
    // identity values are arbitrary
    localparam logic [15:0] TB_MAKER = 16'h1AB0;
    localparam logic [15:0] TB_FUNC = 16'h0C51;
    localparam logic [7:0] TB_REV = 8'h01;
    // expected dwords 0..17 after reset, and after writing all ones everywhere
    localparam logic [31:0] RST_TBL [18] = '{{TB_FUNC, TB_MAKER}, 32'h00A0_0000,
        {16'h0604, 8'h00, TB_REV}, 32'h0001_0000, 32'h0, 32'h0, 32'h0, 32'h02A0_00F0,
        32'h0000_FFF0, 32'h0000_FFF0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] ONE_TBL [18] = '{{TB_FUNC, TB_MAKER}, 32'h00A0_0107,
        {16'h0604, 8'h00, TB_REV}, 32'h0001_F800, 32'h0, 32'h0, 32'hF8FF_FF00, 32'h02A0_F0F0,
        32'hFFF0_FFF0, 32'hFFF0_FFF0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0003_0000,
        32'h0000_0001, 32'h0};
    logic ref_clk_in;
    logic reset_n_in;
    logic cfg_req_in;
    bch_req_t cfg_cmd_in;
    logic sse_set_in;
    logic [15:0] dsts_set_in;
    logic cfg_ack_out;
    logic [31:0] cfg_rdata_out;
    bch_ctrl_t ctrl_out;
    logic [31:0] rd;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;

    bch_config_header #(.MAKER_ID(TB_MAKER), .FUNC_ID(TB_FUNC), .REV_ID(TB_REV)) DUT (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .cfg_req_in(cfg_req_in),
        .cfg_cmd_in(cfg_cmd_in),
        .sse_set_in(sse_set_in),
        .dsts_set_in(dsts_set_in),
        .cfg_ack_out(cfg_ack_out),
        .cfg_rdata_out(cfg_rdata_out),
        .ctrl_out(ctrl_out)
    );

    // 20 MHz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one access: request for one cycle, then bounded wait for the answer strobe
    task automatic cfg_acc(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                           input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        cfg_req_in <= 1'b1;
        cfg_cmd_in <= {wr, dw, be, wd};
        @(posedge ref_clk_in);
        cfg_req_in <= 1'b0;
        #1;
        while (cfg_ack_out !== 1'b1 && n < 4) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        `CHK(cfg_ack_out, 1'b1)
        rd = cfg_rdata_out;
    endtask

    task automatic rd_chk(input logic [5:0] dw, input logic [31:0] exp);
        cfg_acc(1'b0, dw, 4'h0, 32'h0);
        `CHK(rd, exp)
    endtask

    // reset held for 4 cycles, then dwords 0..17 and 6'h3F compared with their reset image
    task automatic reset_and_scan();
        @(posedge ref_clk_in);
        reset_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        `CHK(cfg_ack_out, 1'b0)
        reset_n_in <= 1'b1;
        for (int i = 0; i < 18; i++) begin
            rd_chk(i[5:0], RST_TBL[i]);
        end
        rd_chk(6'h07, 32'h02A0_00F0);
        rd_chk(6'h09, 32'h0000_FFF0);
        rd_chk(6'h0F, 32'h0);
        rd_chk(6'h3F, 32'h0);
    endtask

    initial begin
        reset_n_in = 1'b0;
        cfg_req_in = 1'b0;
        cfg_cmd_in = '0;
        sse_set_in = 1'b0;
        dsts_set_in = 16'h0000;
        reset_and_scan();
        // all ones into dwords 0..17 and 6'h3F, reserved ones included: only writable bits stick
        for (int i = 0; i < 18; i++) begin
            cfg_acc(1'b1, i[5:0], 4'hF, 32'hFFFF_FFFF);
        end
        cfg_acc(1'b1, 6'h3F, 4'hF, 32'hFFFF_FFFF);
        for (int i = 0; i < 18; i++) begin
            rd_chk(i[5:0], ONE_TBL[i]);
        end
        rd_chk(6'h09, 32'hFFF0_FFF0);
        rd_chk(6'h0F, 32'h0003_0000);
        rd_chk(6'h3F, 32'h0);
        `CHK(ctrl_out.mem_base, 16'hFFF0)
        // one byte lane only, then a write with no lanes enabled
        cfg_acc(1'b1, 6'h06, 4'b0010, 32'h0000_2A00);
        `CHK(ctrl_out.dbus, 8'h2A)
        `CHK(ctrl_out.hbus, 8'hFF)
        rd_chk(6'h06, 32'hF8FF_2A00);
        cfg_acc(1'b1, 6'h08, 4'h0, 32'h0);
        rd_chk(6'h08, 32'hFFF0_FFF0);
        // status events, then clear with ones through the upper lanes only
        @(posedge ref_clk_in);
        sse_set_in <= 1'b1;
        dsts_set_in <= 16'hFFFF;
        @(posedge ref_clk_in);
        sse_set_in <= 1'b0;
        dsts_set_in <= 16'h0000;
        rd_chk(6'h07, 32'hF3A0_F0F0);
        rd_chk(6'h01, 32'h40A0_0107);
        cfg_acc(1'b1, 6'h01, 4'b1100, 32'hFFFF_0000);
        rd_chk(6'h01, 32'h00A0_0107);
        cfg_acc(1'b1, 6'h07, 4'b1100, 32'h1000_0000);
        rd_chk(6'h07, 32'hE3A0_F0F0);
        cfg_acc(1'b1, 6'h07, 4'b1100, 32'hFFFF_0000);
        rd_chk(6'h07, 32'h02A0_F0F0);
        // second reset in mid-run brings every register back
        reset_and_scan();
        end_sim();
    end
endmodule // bch_config_header_tb_top
